// *** tcp_pkg.sv ***
// Package with shared constants for the timer, counter and PWM block.
`default_nettype none
package tcp_pkg;
  localparam int CounterWidth = 16;
  localparam int UnitCount = 5;
  localparam logic [15:0] CountReset = 16'h0000;
  localparam logic [15:0] PeriodReset = 16'hFFFF;
  localparam logic [15:0] CompareReset = 16'h0000;
  localparam logic [15:0] DeadReset = 16'h0000;
  localparam logic [15:0] PrescaleReset = 16'h0000;
  typedef enum logic [2:0] {
    StIdle = 3'b001,
    StRun = 3'b010,
    StHalt = 3'b100
  } tcp_state_e;
endpackage
`default_nettype wire

// *** tcp_unit.sv ***
// One timer, counter and PWM unit with capture, compare and dead band.
`timescale 1ns/10ps
`default_nettype none
module tcp_unit
  import tcp_pkg::*;
#(
  parameter int Width = CounterWidth
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Configuration.
  input wire logic enable,
  input wire logic oneShot,
  input wire logic [Width-1:0] prescale,
  input wire logic [Width-1:0] period,
  input wire logic [Width-1:0] compare,
  input wire logic [Width-1:0] deadTime,
  input wire logic killLevelTrue,
  input wire logic killLevelComp,
  // Synchronised events.
  input wire logic captureSync,
  input wire logic killSync,
  // Results.
  output logic [Width-1:0] count_q,
  output logic [Width-1:0] capture_q,
  output logic captured_q,
  output logic running_q,
  output logic pwmTrue_q,
  output logic pwmComp_q
);
  tcp_state_e state_q;
  logic [Width-1:0] div_q;
  logic [Width-1:0] deadCnt_q;
  logic capPrev_q;
  logic cmpRaw_q;
  logic cmpPrev_q;
  logic tick;
  logic atPeriod;
  assign tick = (div_q == prescale);
  assign atPeriod = (count_q == period);

  // Divider that forms the peripheral clock enable.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      div_q <= '0;
    end else if (!enable || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // Counter with reload or halt at the period.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= StIdle;
      count_q <= '0;
    end else if (!enable) begin
      state_q <= StIdle;
      count_q <= '0;
    end else begin
      case (state_q)
        StIdle: begin
          state_q <= StRun;
        end
        StRun: begin
          if (tick) begin
            if (atPeriod) begin
              count_q <= oneShot ? count_q : '0;
              state_q <= oneShot ? StHalt : StRun;
            end else begin
              count_q <= count_q + 1'b1;
            end
          end
        end
        StHalt: begin
          state_q <= StHalt;
        end
        default: begin
          state_q <= StIdle;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      running_q <= 1'b0;
    end else begin
      running_q <= enable && (state_q != StHalt);
    end
  end

  // Capture on a rising event edge; a new event wins over re-arming.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      capPrev_q <= 1'b0;
      capture_q <= '0;
      captured_q <= 1'b0;
    end else begin
      capPrev_q <= captureSync;
      captured_q <= 1'b0;
      if (captureSync && !capPrev_q) begin
        capture_q <= count_q;
        captured_q <= 1'b1;
      end
    end
  end

  // Compare and dead-band insertion on both edges of the raw PWM.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cmpRaw_q <= 1'b0;
      cmpPrev_q <= 1'b0;
      deadCnt_q <= '0;
    end else begin
      cmpRaw_q <= enable && (count_q < compare);
      cmpPrev_q <= cmpRaw_q;
      if (cmpRaw_q != cmpPrev_q) begin
        deadCnt_q <= deadTime;
      end else if (deadCnt_q != '0) begin
        deadCnt_q <= deadCnt_q - 1'b1;
      end
    end
  end

  // Outputs; the kill path overrides the PWM path, one clock after killSync.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pwmTrue_q <= 1'b0;
      pwmComp_q <= 1'b0;
    end else if (killSync) begin
      pwmTrue_q <= killLevelTrue;
      pwmComp_q <= killLevelComp;
    end else begin
      pwmTrue_q <= cmpRaw_q && (cmpRaw_q == cmpPrev_q) && (deadCnt_q == '0);
      pwmComp_q <= !cmpRaw_q && (cmpRaw_q == cmpPrev_q) && (deadCnt_q == '0);
    end
  end
endmodule
`default_nettype wire

// *** tcp_timer_counter_pwm_unit.sv ***
// Five independent timer, counter and PWM units with pin synchronisers.
//
// Behaviour
// - Each unit has a 16-bit counter whose period comes from a period input.
// - A capture event copies the current count into the capture register.
// - At count equal period the counter halts or reloads as configured.
// - Counter compared to compare value gives the PWM duty-cycle signal.
// - True and complementary outputs have edges separated by programmed dead time.
// - Kill input forces outputs to preset levels without software action.
// - Five independent units each with counter, period, capture and compare.
`timescale 1ns/10ps
`default_nettype none
module tcp_timer_counter_pwm_unit
  import tcp_pkg::*;
#(
  parameter int Units = UnitCount,
  parameter int Width = CounterWidth
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Per-unit configuration.
  input wire logic [Units-1:0] enable,
  input wire logic [Units-1:0] oneShot,
  input wire logic [Units*Width-1:0] prescale,
  input wire logic [Units*Width-1:0] period,
  input wire logic [Units*Width-1:0] compare,
  input wire logic [Units*Width-1:0] deadTime,
  input wire logic [Units-1:0] killLevelTrue,
  input wire logic [Units-1:0] killLevelComp,
  // Pins.
  input wire logic [Units-1:0] capturePin,
  input wire logic [Units-1:0] killPin,
  // Status.
  output logic [Units*Width-1:0] count,
  output logic [Units*Width-1:0] capture,
  output logic [Units-1:0] captured,
  output logic [Units-1:0] running,
  // PWM outputs.
  output logic [Units-1:0] pwmTrue,
  output logic [Units-1:0] pwmComp
);
  // Refuse parameter sets that the slicing and the counters cannot serve.
  if (Units < 1 || Width < 2) begin : gBadParams
    $error("tcp_timer_counter_pwm_unit: unsupported parameters");
  end

  logic [Units-1:0] capMeta_q;
  logic [Units-1:0] capSync_q;
  logic [Units-1:0] killMeta_q;
  logic [Units-1:0] killSync_q;

  // Two-stage synchronisers for the pin inputs.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      capMeta_q <= '0;
      capSync_q <= '0;
      killMeta_q <= '0;
      killSync_q <= '0;
    end else begin
      capMeta_q <= capturePin;
      capSync_q <= capMeta_q;
      killMeta_q <= killPin;
      killSync_q <= killMeta_q;
    end
  end

  for (genvar i = 0; i < Units; i++) begin : gUnit
    tcp_unit #(
      .Width(Width)
    ) uUnit (
      .clock(clock),
      .reset(reset),
      .enable(enable[i]),
      .oneShot(oneShot[i]),
      .prescale(prescale[i*Width +: Width]),
      .period(period[i*Width +: Width]),
      .compare(compare[i*Width +: Width]),
      .deadTime(deadTime[i*Width +: Width]),
      .killLevelTrue(killLevelTrue[i]),
      .killLevelComp(killLevelComp[i]),
      .captureSync(capSync_q[i]),
      .killSync(killSync_q[i]),
      .count_q(count[i*Width +: Width]),
      .capture_q(capture[i*Width +: Width]),
      .captured_q(captured[i]),
      .running_q(running[i]),
      .pwmTrue_q(pwmTrue[i]),
      .pwmComp_q(pwmComp[i])
    );
  end
endmodule
`default_nettype wire

// *** tcp_properties.sv ***
// Checker for unit 0 of the timer, counter and PWM block.
`timescale 1ns/10ps
`default_nettype none
module tcp_properties (
  input wire logic clock,
  input wire logic reset,
  input wire logic [4:0] enable,
  input wire logic [4:0] oneShot,
  input wire logic [79:0] period,
  input wire logic [79:0] compare,
  input wire logic [4:0] killPin,
  input wire logic [4:0] killLevelTrue,
  input wire logic [4:0] killLevelComp,
  input wire logic [79:0] count,
  input wire logic [79:0] capture,
  input wire logic [4:0] captured,
  input wire logic [4:0] running,
  input wire logic [4:0] pwmTrue,
  input wire logic [4:0] pwmComp
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic [15:0] c;
  logic [15:0] p;
  logic lt_q;
  assign c = count[15:0];
  assign p = period[15:0];
  always_ff @(posedge clock or posedge reset)
    if (reset)
      lt_q <= 1'b0;
    else
      lt_q <= c < compare[15:0];
  property p_step;
    enable[0] && running[0] && c != p ##1 enable[0] |-> c == $past(c) + 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("step");
  property p_clear;
    !enable[0] |=> c == 16'h0000;
  endproperty
  a_clear: assert property (p_clear) else $error("clear");
  property p_reload;
    enable[0] && running[0] && !oneShot[0] && c == p ##1 enable[0] |-> c == 16'h0000;
  endproperty
  a_reload: assert property (p_reload) else $error("reload");
  property p_halt;
    enable[0] && oneShot[0] && c == p ##1 enable[0] |-> $stable(c) ##1 !running[0];
  endproperty
  a_halt: assert property (p_halt) else $error("halt");
  property p_capVal;
    captured[0] |-> capture[15:0] == $past(c);
  endproperty
  a_capVal: assert property (p_capVal) else $error("capture");
  property p_kill;
    killPin[0] [*5] |-> pwmTrue[0] == killLevelTrue[0] && pwmComp[0] == killLevelComp[0];
  endproperty
  a_kill: assert property (p_kill) else $error("kill");
  property p_dead;
    $fell(pwmComp[0]) && !killPin[0] |-> !pwmTrue[0] [*3];
  endproperty
  a_dead: assert property (p_dead) else $error("dead band");
  property p_duty;
    $rose(pwmTrue[0]) && !killPin[0] |-> $past(lt_q, 3);
  endproperty
  a_duty: assert property (p_duty) else $error("duty");
endmodule
`default_nettype wire

// *** tcp_switch_model.sv ***
// Half-bridge switch pair driven by the true and complementary outputs.
`timescale 1ns/10ps
`default_nettype none
module tcp_switch_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic gateHigh,
  input wire logic gateLow,
  output logic shoot_q
);
  // Both switches on shorts the supply, so the fault is latched.
  always_ff @(posedge clock or posedge reset)
    if (reset)
      shoot_q <= 1'b0;
    else if (gateHigh && gateLow)
      shoot_q <= 1'b1;
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the timer, counter and PWM block.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clock = 0;
  logic reset = 1;
  logic [4:0] enable = 0, oneShot = 0, killLevelTrue = 1, killLevelComp = 0;
  logic [4:0] capturePin = 0, killPin = 0, captured, running, pwmTrue, pwmComp, shoot;
  logic [79:0] prescale = 0, period = 0, compare = 0, deadTime = 0, count, capture;
  logic [15:0] seed = 16'h0046, r, q[5][$];
  int miscompares = 0, num_checks = 0;
  function automatic logic [15:0] rnd();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed;
  endfunction
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (miscompares == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial forever #2 clock = ~clock;
  tcp_timer_counter_pwm_unit u_tcp_timer_counter_pwm_unit (.clock, .reset, .enable, .oneShot,
    .prescale, .period, .compare, .deadTime, .killLevelTrue, .killLevelComp, .capturePin,
    .killPin, .count, .capture, .captured, .running, .pwmTrue, .pwmComp);
  tcp_switch_model u_tcp_switch_model[4:0] (.clock, .reset, .gateHigh(pwmTrue),
    .gateLow(pwmComp), .shoot_q(shoot));
  always @(posedge clock)
    for (int i = 0; i < 5; i++)
      if (captured[i] === 1'b1)
        check("capture", capture[i*16+:16], q[i].size() ? q[i].pop_front() : 16'hFFFF);
  initial begin
    #20000;
    miscompares++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    period[15:0] <= 16'h0013;
    compare[15:0] <= 16'h0008;
    deadTime[15:0] <= 16'h0002;
    enable[0] <= 1'b1;
    repeat (100) @(posedge clock);
    enable <= 5'h00;
    @(posedge clock);
    for (int i = 0; i < 5; i++) begin
      r = rnd();
      period[i*16+:16] <= {8'h00, r[7:0]} + 16'h0001;
      compare[i*16+:16] <= {8'h00, r[15:8]};
      q[i].push_back({8'h00, r[7:0]} + 16'h0001);
      if (i > 0) begin
        prescale[i*16+:16] <= {14'h0000, r[9:8]};
        deadTime[i*16+:16] <= {13'h0000, r[3:1]};
        killLevelTrue[i] <= r[4];
        killLevelComp[i] <= r[5] & ~r[4];
      end
    end
    oneShot <= 5'h1F;
    @(posedge clock);
    enable <= 5'h1F;
    repeat (1100) @(posedge clock);
    capturePin <= 5'h1F;
    repeat (4) @(posedge clock);
    capturePin <= 5'h00;
    killPin <= 5'h1F;
    repeat (6) @(posedge clock);
    for (int i = 0; i < 5; i++) begin
      check("count", count[i*16+:16], period[i*16+:16]);
      check("running", {15'h0000, running[i]}, 16'h0000);
      check("pwmTrue", {15'h0000, pwmTrue[i]}, {15'h0000, killLevelTrue[i]});
      check("pwmComp", {15'h0000, pwmComp[i]}, {15'h0000, killLevelComp[i]});
      check("pending", 16'(q[i].size()), 16'h0000);
    end
    killPin <= 5'h00;
    repeat (4) @(posedge clock);
    check("shoot", {11'h000, shoot}, 16'h0000);
    complete_run();
  end
endmodule
bind tcp_timer_counter_pwm_unit tcp_properties u_tcp_properties (.clock, .reset, .enable,
  .oneShot, .period, .compare, .killPin, .killLevelTrue, .killLevelComp, .count, .capture,
  .captured, .running, .pwmTrue, .pwmComp);
`default_nettype wire
